// >>> hw/rel_top.sv
// APB register bank that logs receive link errors and raises irq and reinit
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rel_top
  import rel_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_running,
  input wire logic [LANES-1:0] pcfifo_empty_lane,
  input wire logic [LANES-1:0] pcfifo_full_lane,
  input wire logic [LANES-1:0] lane_lock_event_flag,
  input wire logic deskew_err,
  input wire logic tl_valid,
  input wire logic transport_sink_ready,
  input wire logic link_valid,
  input wire logic link_sink_ready,
  input wire logic sysref,
  input wire logic cg_sync_err,
  output logic irq,
  output logic link_reinit_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  rel_apb_st_t st_r;
  rel_apb_st_t st_nxt;
  logic [STAT_W-1:0] status_r;
  logic [STAT_W-1:0] status_nxt;
  logic [STAT_W-1:0] irq_en_r;
  logic [STAT_W-1:0] reinit_en_r;
  logic [LMFC_W-1:0] lmfc_cfg_r;
  logic always_on_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic reinit_r;
  logic sysref_mismatch;
  rel_evt_t evt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire sel_lmfc = hit(paddr, OFS_LMFC_CFG);
  wire sel_sysref = hit(paddr, OFS_SYSREF_CTRL);
  wire sel_spare = hit(paddr, OFS_CTRL_SPARE);
  wire sel_status = hit(paddr, OFS_STATUS_A);
  wire sel_irq_en = hit(paddr, OFS_IRQ_EN);
  wire sel_reinit_en = hit(paddr, OFS_REINIT_EN);
  wire mapped = sel_lmfc | sel_sysref | sel_spare | sel_status | sel_irq_en
                | sel_reinit_en;

  // Access completes in the cycle after the access phase begins
  wire in_access = psel & penable;
  wire complete = in_access & (st_r == REL_WAIT);
  wire wr_commit = complete & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave phase sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      REL_IDLE: begin
        if (in_access) begin
          st_nxt = REL_WAIT;
        end
      end
      REL_WAIT: begin
        st_nxt = REL_DONE;
      end
      REL_DONE: begin
        st_nxt = REL_IDLE;
      end
      default: begin
        st_nxt = REL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection, reserved bits read as zero
  wire [31:0] rd_word =
    sel_lmfc ? {{(32-LMFC_W){1'b0}}, lmfc_cfg_r} :
    sel_sysref ? (WORD_ZERO | (32'h0000_0001 << BIT_ALWAYSON) & {32{always_on_r}}) :
    sel_status ? {{(32-STAT_W){1'b0}}, status_r} :
    sel_irq_en ? {{(32-STAT_W){1'b0}}, irq_en_r} :
    sel_reinit_en ? {{(32-STAT_W){1'b0}}, reinit_en_r} :
    WORD_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware events gathered onto the status layout
  assign evt.spare_error_flag_four = 1'b0;
  assign evt.pcf_empty = link_running & (|pcfifo_empty_lane);
  assign evt.pcf_full = link_running & (|pcfifo_full_lane);
  assign evt.lane_lock = link_running & (|lane_lock_event_flag);
  assign evt.deskew = deskew_err;
  // A sink ready tied high never flags
  assign evt.frame_ready = tl_valid & ~transport_sink_ready;
  assign evt.link_ready = link_valid & ~link_sink_ready;
  assign evt.sysref_lmfc = sysref_mismatch;
  assign evt.unused_zero = 1'b0;

  // Write one clears, then set wins over clear in the same cycle
  wire [STAT_W-1:0] clr_mask = (wr_commit & sel_status) ? pwdata[STAT_W-1:0] : STAT_RESET;
  assign status_nxt = ((status_r & ~clr_mask) | evt) & STAT_IMPL_MASK;

  // Interrupt and reinit conditions
  wire irq_nxt = |(status_nxt & irq_en_r);
  wire reinit_nxt = (|(status_nxt & reinit_en_r)) | cg_sync_err;

  ////////////////////////////////////////////////////////////////////////////
  // LMFC period checker
  rel_lmfc_chk #(
    .CNT_W(LMFC_W)
  ) u_lmfc (
    .pclk(pclk),
    .presetn(presetn),
    .always_on(always_on_r),
    .period_m1(lmfc_cfg_r),
    .sysref(sysref),
    .mismatch(sysref_mismatch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= REL_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= WORD_ZERO;
    end else begin
      st_r <= st_nxt;
      pready_r <= in_access & (st_r == REL_IDLE);
      pslverr_r <= in_access & (st_r == REL_IDLE) & ~mapped;
      if (in_access & (st_r == REL_IDLE) & ~pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= EN_RESET;
      reinit_en_r <= EN_RESET;
      lmfc_cfg_r <= LMFC_CFG_RESET;
      always_on_r <= 1'b0;
    end else if (wr_commit) begin
      if (sel_irq_en) begin
        irq_en_r <= pwdata[STAT_W-1:0] & STAT_IMPL_MASK;
      end
      if (sel_reinit_en) begin
        reinit_en_r <= pwdata[STAT_W-1:0] & STAT_IMPL_MASK;
      end
      if (sel_lmfc) begin
        lmfc_cfg_r <= pwdata[LMFC_W-1:0];
      end
      if (sel_sysref) begin
        always_on_r <= pwdata[BIT_ALWAYSON];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and the two request outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= STAT_RESET;
      irq_r <= 1'b0;
      reinit_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= irq_nxt;
      reinit_r <= reinit_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign link_reinit_req = reinit_r;

endmodule
`default_nettype wire

// >>> hw/rel_pkg.sv
// Package of constants and types for the receive error log block
`default_nettype none
package rel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_LMFC_CFG = 8'h50;
  localparam logic [7:0] OFS_SYSREF_CTRL = 8'h54;
  localparam logic [7:0] OFS_CTRL_SPARE = 8'h58;
  localparam logic [7:0] OFS_STATUS_A = 8'h60;
  localparam logic [7:0] OFS_IRQ_EN = 8'h74;
  localparam logic [7:0] OFS_REINIT_EN = 8'h78;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout of the status word, its enable words and the LMFC and SYSREF control words
  localparam int STAT_W = 9;
  localparam int BIT_SPARE_FOUR = 8;
  localparam int BIT_PCF_EMPTY = 7;
  localparam int BIT_PCF_FULL = 6;
  localparam int BIT_LANE_LOCK = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_FRAME_READY = 3;
  localparam int BIT_LINK_READY = 2;
  localparam int BIT_SYSREF_LMFC = 1;
  localparam int BIT_ALWAYSON = 1;
  localparam int LMFC_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and masks
  localparam logic [STAT_W-1:0] STAT_RESET = 9'h000;
  localparam logic [STAT_W-1:0] STAT_IMPL_MASK = 9'h1FE;
  localparam logic [STAT_W-1:0] EN_RESET = 9'h000;
  localparam logic [LMFC_W-1:0] LMFC_CFG_RESET = 8'h0F;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Event vector, one field per status bit, bit 8 down to bit 0
  typedef struct packed {
    logic spare_error_flag_four;
    logic pcf_empty;
    logic pcf_full;
    logic lane_lock;
    logic deskew;
    logic frame_ready;
    logic link_ready;
    logic sysref_lmfc;
    logic unused_zero;
  } rel_evt_t;

  // Bus access phases of the slave
  typedef enum logic [1:0] {
    REL_IDLE,
    REL_WAIT,
    REL_DONE
  } rel_apb_st_t;

endpackage
`default_nettype wire

// >>> hw/rel_lmfc_chk.sv
// LMFC counter with SYSREF realignment and period mismatch detection
`timescale 1ns/1ps
`default_nettype none
module rel_lmfc_chk
  import rel_pkg::*;
#(
  parameter int CNT_W = LMFC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic always_on,
  input wire logic [CNT_W-1:0] period_m1,
  input wire logic sysref,
  output logic mismatch
);

  logic sysref_d_r;
  logic armed_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic mismatch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect and boundary decode
  wire rise = sysref & ~sysref_d_r;
  wire at_last = (cnt_r == period_m1);
  wire realign = always_on & rise;
  // Edge off the multiframe boundary means period is no whole multiple
  wire bad_edge = realign & armed_r & ~at_last;

  // Counter restarts at every edge in continuous mode, else wraps to zero after period_m1
  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    if (realign | at_last) begin
      cnt_nxt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, arming and flag pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_d_r <= 1'b0;
      armed_r <= 1'b0;
      cnt_r <= '0;
      mismatch_r <= 1'b0;
    end else begin
      sysref_d_r <= sysref;
      cnt_r <= cnt_nxt;
      armed_r <= always_on & (armed_r | rise);
      mismatch_r <= bad_edge;
    end
  end

  assign mismatch = mismatch_r;

endmodule
`default_nettype wire

// >>> verification/rel_checker.sv
// Checker of bus timing and of the irq and reinit outputs
`timescale 1ns/1ps
`default_nettype none
module rel_checker
  import rel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cg_sync_err,
  input wire logic irq,
  input wire logic link_reinit_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wdone = pwrite & pready;
  wire logic mapped = paddr inside {OFS_LMFC_CFG, OFS_SYSREF_CTRL, OFS_CTRL_SPARE,
                                    OFS_STATUS_A, OFS_IRQ_EN, OFS_REINIT_EN};
  ////////////////////////////////////////
  // First access cycle, then the completing cycle
  sequence acc_s;
    psel && penable && !$past(penable);
  endsequence
  sequence done_s;
    pready && psel && penable;
  endsequence
  wait_a: assert property (acc_s |=> done_s) else $error("no single wait state");
  once_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  hold_a: assert property (pready |-> done_s ##0 $past(psel && !penable, 2))
    else $error("pready without setup and access");
  err_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  map_a: assert property (pready |-> pslverr == !mapped) else $error("wrong slave error");
  ////////////////////////////////////////
  // Output levels tied to their causes
  cg_force_a: assert property (cg_sync_err |=> link_reinit_req)
    else $error("code group error gave no reinit");
  // A status clear drops the output one cycle after the write, an enable clear two
  irq_fall_a: assert property ($fell(irq) |-> $past(wdone) || $past(wdone, 2))
    else $error("irq fell without a write");
  reinit_fall_a: assert property ($fell(link_reinit_req)
    |-> $past(wdone) || $past(wdone, 2) || $past(cg_sync_err, 2))
    else $error("reinit fell alone");
endmodule
bind rel_top rel_checker rel_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cg_sync_err(cg_sync_err), .irq(irq), .link_reinit_req(link_reinit_req));
`default_nettype wire

// >>> verification/rel_far_model.sv
// Transport side model: periodic SYSREF and a stallable link ready
`timescale 1ns/1ps
`default_nettype none
module rel_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] period,
  input wire logic stall,
  output logic sysref,
  output logic link_sink_ready
);
  logic [7:0] cnt_r;
  // Ready stays high unless a stall is commanded
  assign link_sink_ready = !stall;
  // One-cycle pulse every period clocks, silent at period zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      sysref <= 1'b0;
    end else if (period == 8'h00) begin
      cnt_r <= 8'h00;
      sysref <= 1'b0;
    end else begin
      sysref <= (cnt_r == 8'h00);
      cnt_r <= (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> verification/rel_top_tb.sv
// Testbench of the receive error log register bank
`timescale 1ns/1ps
`default_nettype none
module rel_top_tb
  import rel_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, stall = 0;
  logic [7:0] paddr = 8'h00, per = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, reinit, sysref, lsr;
  logic run = 1, dsk = 0, tlv = 0, tsr = 1, lv = 0, cg = 0;
  logic [3:0] pce = 4'h0, pcf = 4'h0, lock = 4'h0;
  int n_errors = 0, cmp_count = 0;
  initial forever #5 pclk = ~pclk;
  rel_top rel_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_running(run), .pcfifo_empty_lane(pce), .pcfifo_full_lane(pcf),
    .lane_lock_event_flag(lock), .deskew_err(dsk), .tl_valid(tlv),
    .transport_sink_ready(tsr), .link_valid(lv), .link_sink_ready(lsr), .sysref(sysref),
    .cg_sync_err(cg), .irq(irq), .link_reinit_req(reinit));
  rel_far_model rel_far_model_i (.pclk(pclk), .presetn(presetn), .period(per),
    .stall(stall), .sysref(sysref), .link_sink_ready(lsr));
  ////////////////////////////////////////
  // Compare, bus cycle, event pulse and verdict
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Request held until pready is sampled high at a rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR apb no pready at %h", a);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic fire(int b);
    @(posedge pclk);
    case (b)
      7: pce <= 4'h2;
      6: pcf <= 4'h8;
      5: lock <= 4'h1;
      4: dsk <= 1;
      3: {tlv, tsr} <= 2'b10;
      default: {lv, stall} <= 2'b11;
    endcase
    @(posedge pclk);
    {pce, pcf, lock, dsk, tlv, tsr, lv, stall} <= {12'h000, 5'b00100};
    repeat (3) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_STATUS_A, 0);
    chk("status", rd, 0);
    apb(0, OFS_LMFC_CFG, 0);
    chk("lmfc", rd, 32'h0000_000F);
    apb(1, OFS_CTRL_SPARE, 32'hFFFF_FFFF);
    apb(0, OFS_CTRL_SPARE, 0);
    chk("spare", rd, 0);
    apb(1, OFS_STATUS_A, 32'h0000_0100);
    apb(0, OFS_STATUS_A, 0);
    chk("bit8", rd, 0);
    apb(0, 8'h10, 0);
    chk("unmapped", er, 1);
    {pce, tlv, lv, run} <= 7'b1111110;
    repeat (4) @(posedge pclk);
    {pce, tlv, lv, run} <= 7'b0000001;
    apb(0, OFS_STATUS_A, 0);
    chk("quiet", rd, 0);
    apb(1, OFS_IRQ_EN, 32'h0000_01FF);
    apb(0, OFS_IRQ_EN, 0);
    chk("irq_en", rd, 32'h0000_01FE);
    for (int b = 2; b < 8; b++) begin
      fire(b);
      chk("irq", irq, 1);
      apb(0, OFS_STATUS_A, 0);
      chk("flag", rd, 32'h1 << b);
      apb(1, OFS_STATUS_A, 32'h1 << b);
      repeat (2) @(posedge pclk);
      chk("irq", irq, 0);
    end
    apb(1, OFS_IRQ_EN, 0);
    apb(1, OFS_REINIT_EN, 32'h0000_01FE);
    apb(0, OFS_REINIT_EN, 0);
    chk("reinit_en", rd, 32'h0000_01FE);
    fire(4);
    chk("masked", irq, 0);
    chk("reinit", reinit, 1);
    dsk <= 1;
    apb(1, OFS_STATUS_A, 32'h0000_0010);
    apb(0, OFS_STATUS_A, 0);
    chk("setwins", rd, 32'h0000_0010);
    dsk <= 0;
    apb(1, OFS_STATUS_A, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    chk("reinit", reinit, 0);
    apb(1, OFS_REINIT_EN, 0);
    cg <= 1;
    repeat (2) @(posedge pclk);
    chk("cg", reinit, 1);
    cg <= 0;
    apb(1, OFS_LMFC_CFG, 32'h0000_0007);
    per <= 8'h10;
    apb(1, OFS_SYSREF_CTRL, 32'h0000_0002);
    apb(0, OFS_SYSREF_CTRL, 0);
    chk("always_on", rd, 32'h0000_0002);
    repeat (80) @(posedge pclk);
    apb(0, OFS_STATUS_A, 0);
    chk("sref ok", rd, 0);
    per <= 8'h0D;
    repeat (80) @(posedge pclk);
    apb(0, OFS_STATUS_A, 0);
    chk("sref bad", rd, 32'h0000_0002);
    // FIFO flag answered by the controller with a link reset
    fire(7);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_STATUS_A, 0);
    chk("relink", rd, 0);
    chk("relink irq", irq, 0);
    chk("relink reinit", reinit, 0);
    apb(0, OFS_LMFC_CFG, 0);
    chk("relink lmfc", rd, 32'h0000_000F);
    report_and_stop;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
